// ---- test/eeprom_model.sv ----
// Behavioural serial identifier EEPROM answering the byte fetch handshake.
// Assumes requests are held until acknowledged; answer delay is set by the bench.
`timescale 1ns/1ns
module eeprom_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fetch handshake
  input wire logic ee_req,
  input wire logic [7:0] ee_addr,
  output logic ee_ack,
  output logic [7:0] ee_data,
  // Cycles to wait before answering
  input wire logic [3:0] delay
);
  logic [3:0] count; // Cycles waited on the current request

  // Answer one request with a one-cycle ack; stale data toggles otherwise
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ee_ack <= 1'h0;
      ee_data <= 8'h5A;
      count <= 4'h0;
    end
    else if (ee_ack)
    begin
      // Ack only lasts one cycle
      ee_ack <= 1'h0;
      ee_data <= ~ee_data;
      count <= 4'h0;
    end
    else if (ee_req && count >= delay)
    begin
      // Byte content is a fixed pattern of its address
      ee_ack <= 1'h1;
      ee_data <= {ee_addr[3:0], ~ee_addr[3:0]};
    end
    else
    begin
      // Data not valid, so never show a steady value
      ee_data <= ~ee_data;
      count <= ee_req ? count + 4'h1 : 4'h0;
    end
  end
endmodule : eeprom_model

// ---- test/tb_top.sv ----
// Self-checking bench for the EEPROM access and retry register slice.
// Assumes the EEPROM model in the test folder and the design package and header.
`timescale 1ns/1ns
module tb_top;
  // APB and reset
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, cswap_value_in;
  // EEPROM side
  logic eeprom_detect, ee_req, ee_ack, req_seen;
  logic [7:0] ee_addr, ee_data, keep;
  logic [3:0] ee_delay;
  // Retry limits, compare-swap, status
  logic [3:0] phys_max, resp_max, req_max, resource_target;
  logic cswap_load, id_eeprom_present;
  eeprom_regs_pkg::bus_resource_t bus_resource_select;
  int failures, samples_checked;

  eeprom_byte_access_retry_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eeprom_detect(eeprom_detect), .ee_req(ee_req), .ee_addr(ee_addr), .ee_ack(ee_ack), .ee_data(ee_data),
    .physical_response_retry_max(phys_max), .async_response_retry_max(resp_max),
    .async_request_retry_max(req_max), .cswap_load(cswap_load), .cswap_value_in(cswap_value_in),
    .bus_resource_select(bus_resource_select), .resource_target(resource_target),
    .id_eeprom_present(id_eeprom_present));

  eeprom_model rom (.pclk(pclk), .presetn(presetn), .ee_req(ee_req), .ee_addr(ee_addr), .ee_ack(ee_ack),
    .ee_data(ee_data), .delay(ee_delay));

  // Clock
  initial
  begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  // Remember any fetch request
  always @(posedge pclk) if (ee_req === 1'h1) req_seen <= 1'h1;

  // Cut a hang short
  initial
  begin
    #500000;
    failures++;
    report_and_stop();
  end

  // Compare and count
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Verdict
  task report_and_stop;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // One APB transfer; read data and error land in rd and err
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin @(posedge pclk); n++; end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1)
    begin
      failures++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // Read the access register until the masked bits match
  task poll(input logic [31:0] mask, input logic [31:0] val);
    int n;
    n = 0;
    do begin apb(1'h0, 8'h04, 32'h0); n++; end while ((rd & mask) !== val && n < 60);
    if ((rd & mask) !== val)
    begin
      failures++;
      report_and_stop();
    end
  endtask : poll

  // Reset with a chosen EEPROM detect level
  task do_reset(input logic det);
    presetn <= 1'h0;
    eeprom_detect <= det;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    req_seen <= 1'h0;
  endtask : do_reset

  // Main sequence
  initial
  begin
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h0; pwdata = 32'h0;
    eeprom_detect = 1'h1; ee_delay = 4'h0; cswap_load = 1'h0; cswap_value_in = 32'h0;
    bus_resource_select = eeprom_regs_pkg::RES_BUS_MANAGER_ID; req_seen = 1'h0;
    failures = 0; samples_checked = 0;
    do_reset(1'h1);
    // Boot fetch of byte 6 sets the small ROM pointer
    poll(32'h000000FF, 32'h00000020);
    check("access idle", rd & 32'hFF00FFFF, 32'h00000020);
    apb(1'h0, 8'h00, 32'h0);
    check("version", rd, 32'h01010010);
    check("present", {31'h0, id_eeprom_present}, 32'h1);
    apb(1'h0, 8'h08, 32'h0);
    check("retry reset", rd, 32'h0);
    apb(1'h0, 8'h0C, 32'h0);
    check("cswap reset", rd, 32'h0);
    // Retry limits: fixed fields stay zero
    apb(1'h1, 8'h08, 32'hFFFFFFFF);
    apb(1'h0, 8'h08, 32'h0);
    check("retry ones", rd, 32'h00000FFF);
    apb(1'h1, 8'h08, 32'h12345678);
    apb(1'h0, 8'h08, 32'h0);
    check("retry value", rd, 32'h00000678);
    check("retry ports", {20'h0, phys_max, resp_max, req_max}, 32'h00000678);
    // Address clear leaves the read byte alone
    apb(1'h0, 8'h04, 32'h0);
    keep = rd[23:16];
    apb(1'h1, 8'h04, 32'h80000000);
    poll(32'h80000000, 32'h0);
    check("byte after clear", {24'h0, rd[23:16]}, {24'h0, keep});
    // Two fetches, prompt then slow, each with a zero write in flight
    for (int i = 0; i < 2; i++)
    begin
      ee_delay <= (i == 0) ? 4'h0 : 4'h7;
      apb(1'h1, 8'h04, 32'h02000000);
      apb(1'h1, 8'h04, 32'h00FF0000);
      apb(1'h0, 8'h04, 32'h0);
      if (i == 1) check("go pending", rd & 32'h02000000, 32'h02000000);
      poll(32'h02000000, 32'h0);
      check("fetched byte", {24'h0, rd[23:16]}, {24'h0, i[3:0], ~i[3:0]});
    end
    // Compare-swap value loads from the port and ignores writes
    @(posedge pclk);
    cswap_value_in <= 32'hA5C30F96;
    cswap_load <= 1'h1;
    @(posedge pclk);
    cswap_load <= 1'h0;
    apb(1'h1, 8'h0C, 32'h0);
    apb(1'h0, 8'h0C, 32'h0);
    check("cswap value", rd, 32'hA5C30F96);
    // Unmapped offset
    apb(1'h0, 8'h10, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    // Every resource selector code
    for (int i = 0; i < 4; i++)
    begin
      @(posedge pclk);
      bus_resource_select <= eeprom_regs_pkg::bus_resource_t'(i[1:0]);
      @(posedge pclk);
      @(negedge pclk);
      check("resource target", {28'h0, resource_target}, 32'h1 << i);
    end
    // No EEPROM: flag clear, pointer default, go ends without a request
    @(posedge pclk);
    do_reset(1'h0);
    apb(1'h0, 8'h00, 32'h0);
    check("version absent", rd, 32'h00010010);
    apb(1'h0, 8'h04, 32'h0);
    check("small rom default", {24'h0, rd[7:0]}, 32'h0);
    apb(1'h1, 8'h04, 32'h02000000);
    poll(32'h02000000, 32'h0);
    check("no request", {31'h0, req_seen}, 32'h0);
    report_and_stop();
  end
endmodule : tb_top

// ---- verilog/eeprom_byte_access_retry_regs.sv ----
// APB register slice: EEPROM byte access, transmit retry limits, compare-swap value.
// Assumes zero-wait APB, a synchronous EEPROM detect level and a byte fetch handshake.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`include "eeprom_regs_consts.svh"
module eeprom_byte_access_retry_regs #(
  parameter int ADDR_W = 8,
  parameter int RETRY_W = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // EEPROM side
  input wire logic eeprom_detect,
  output logic ee_req,
  output logic [ADDR_W-1:0] ee_addr,
  input wire logic ee_ack,
  input wire logic [7:0] ee_data,
  // Retry limits to transmit units
  output logic [RETRY_W-1:0] physical_response_retry_max,
  output logic [RETRY_W-1:0] async_response_retry_max,
  output logic [RETRY_W-1:0] async_request_retry_max,
  // Compare-swap path
  input wire logic cswap_load,
  input wire logic [31:0] cswap_value_in,
  input wire eeprom_regs_pkg::bus_resource_t bus_resource_select,
  output logic [3:0] resource_target,
  // Status
  output logic id_eeprom_present
);

  eeprom_regs_pkg::access_state_t state, next_state; // Sequencer state
  logic eeprom_address_clear, next_eeprom_address_clear; // Self-clearing address clear
  logic eeprom_read_go, next_eeprom_read_go; // Self-clearing read go
  logic [ADDR_W-1:0] byte_addr, next_byte_addr; // Internal EEPROM byte address
  logic [7:0] eeprom_read_byte, next_eeprom_read_byte; // Last fetched byte
  logic [7:0] small_rom_offset, next_small_rom_offset; // Mini ROM pointer
  logic next_id_eeprom_present; // Detect capture
  logic [31:0] compare_swap_new_value, next_compare_swap_new_value; // New value word
  logic [RETRY_W-1:0] next_phys_max, next_resp_max, next_req_max; // Retry limits
  logic [31:0] next_prdata; // Read data
  logic next_pslverr; // Unmapped answer
  logic [3:0] next_resource_target; // Decoded resource
  logic rd_start; // Fetch launch
  logic [ADDR_W-1:0] rd_addr; // Fetch address
  logic rd_busy; // Fetch in flight
  logic rd_done; // Fetch finished
  logic [7:0] rd_data; // Fetched byte
  logic setup_phase; // APB setup cycle
  logic wr_access; // APB write completes
  logic wr_id; // Write to access register
  logic clear_set; // Software sets address clear
  logic go_set; // Software sets read go

  // APB decode; zero wait states so access equals completion
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign wr_id = wr_access && (paddr == `ADDR_ID_EEPROM);
  assign clear_set = wr_id && pwdata[`EE_CLEAR_BIT];
  assign go_set = wr_id && pwdata[`EE_GO_BIT];

  // Byte fetch engine
  eeprom_byte_reader #(
    .ADDR_W(ADDR_W)
  ) reader (
    .pclk(pclk),
    .presetn(presetn),
    .start(rd_start),
    .addr(rd_addr),
    .busy(rd_busy),
    .done(rd_done),
    .data(rd_data),
    .ee_req(ee_req),
    .ee_addr(ee_addr),
    .ee_ack(ee_ack),
    .ee_data(ee_data)
  );

  // Sequencer: boot detect, address clear, software reads
  always_comb
  begin
    next_state = state;
    next_eeprom_address_clear = eeprom_address_clear | clear_set;
    next_eeprom_read_go = eeprom_read_go | go_set;
    next_byte_addr = byte_addr;
    next_eeprom_read_byte = eeprom_read_byte;
    next_small_rom_offset = small_rom_offset;
    next_id_eeprom_present = id_eeprom_present;
    rd_start = 1'b0;
    rd_addr = byte_addr;
    case (state)
      eeprom_regs_pkg::ST_BOOT:
      begin
        // Catch detect level after reset release
        next_id_eeprom_present = eeprom_detect;
        if (eeprom_detect)
        begin
          // Boot fetch of the mini ROM flag byte
          rd_start = 1'b1;
          rd_addr = ADDR_W'(`SMALL_ROM_FLAG_ADDR);
          next_state = eeprom_regs_pkg::ST_BOOT_READ;
        end
        else
        begin
          next_state = eeprom_regs_pkg::ST_IDLE;
        end
      end
      eeprom_regs_pkg::ST_BOOT_READ:
      begin
        // Flag bit decides the mini ROM pointer
        if (rd_done)
        begin
          next_small_rom_offset = rd_data[`SMALL_ROM_FLAG_BIT] ? `SMALL_ROM_VALUE : `SMALL_ROM_RESET;
          next_state = eeprom_regs_pkg::ST_IDLE;
        end
      end
      eeprom_regs_pkg::ST_IDLE:
      begin
        if (eeprom_address_clear)
        begin
          // Zero the address only; read byte untouched
          next_byte_addr = '0;
          next_eeprom_address_clear = clear_set;
        end
        else if (eeprom_read_go)
        begin
          if (id_eeprom_present)
          begin
            rd_start = 1'b1;
            next_state = eeprom_regs_pkg::ST_SW_READ;
          end
          else
          begin
            // No EEPROM: finish at once so polling ends
            next_eeprom_read_go = go_set;
          end
        end
      end
      eeprom_regs_pkg::ST_SW_READ:
      begin
        if (rd_done)
        begin
          next_eeprom_read_byte = rd_data;
          next_byte_addr = byte_addr + 1'b1;
          next_eeprom_read_go = go_set;
          next_state = eeprom_regs_pkg::ST_IDLE;
        end
      end
      default:
      begin
        next_state = eeprom_regs_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= eeprom_regs_pkg::ST_BOOT;
      eeprom_address_clear <= 1'b0;
      eeprom_read_go <= 1'b0;
      byte_addr <= '0;
      eeprom_read_byte <= 8'h00;
      small_rom_offset <= `SMALL_ROM_RESET;
      id_eeprom_present <= 1'b0;
    end
    else
    begin
      state <= next_state;
      eeprom_address_clear <= next_eeprom_address_clear;
      eeprom_read_go <= next_eeprom_read_go;
      byte_addr <= next_byte_addr;
      eeprom_read_byte <= next_eeprom_read_byte;
      small_rom_offset <= next_small_rom_offset;
      id_eeprom_present <= next_id_eeprom_present;
    end
  end

  // Register file, read mux and resource decode
  always_comb
  begin
    next_phys_max = physical_response_retry_max;
    next_resp_max = async_response_retry_max;
    next_req_max = async_request_retry_max;
    next_compare_swap_new_value = compare_swap_new_value;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    // Host writes to the retry register
    if (wr_access && (paddr == `ADDR_RETRY))
    begin
      next_phys_max = pwdata[`RETRY_PHYS_LSB +: RETRY_W];
      next_resp_max = pwdata[`RETRY_RESP_LSB +: RETRY_W];
      next_req_max = pwdata[`RETRY_REQ_LSB +: RETRY_W];
    end
    // Only the compare-swap path loads the new value
    if (cswap_load)
    begin
      next_compare_swap_new_value = cswap_value_in;
    end
    // Read data prepared in the setup cycle
    if (setup_phase)
    begin
      case (paddr)
        `ADDR_VERSION:
          next_prdata = {7'h00, id_eeprom_present, `VERSION_MAJOR, 8'h00, `VERSION_MINOR};
        `ADDR_ID_EEPROM:
          next_prdata = {eeprom_address_clear, 5'h00, eeprom_read_go, 1'b0, eeprom_read_byte,
                         8'h00, small_rom_offset};
        `ADDR_RETRY:
          next_prdata = {3'h0, 13'h0000, 4'h0, physical_response_retry_max, async_response_retry_max,
                         async_request_retry_max};
        `ADDR_CSWAP:
          next_prdata = compare_swap_new_value;
        default:
        begin
          next_prdata = 32'h00000000;
          next_pslverr = 1'b1;
        end
      endcase
    end
    else if (psel)
    begin
      next_pslverr = pslverr;
    end
    // One-hot target of the selected resource
    case (bus_resource_select)
      eeprom_regs_pkg::RES_BUS_MANAGER_ID: next_resource_target = 4'h1;
      eeprom_regs_pkg::RES_BANDWIDTH_AVAILABLE: next_resource_target = 4'h2;
      eeprom_regs_pkg::RES_CHANNELS_AVAILABLE_HI: next_resource_target = 4'h4;
      eeprom_regs_pkg::RES_CHANNELS_AVAILABLE_LO: next_resource_target = 4'h8;
      default: next_resource_target = 4'h0;
    endcase
  end

  // Register file registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      physical_response_retry_max <= `RETRY_RESET;
      async_response_retry_max <= `RETRY_RESET;
      async_request_retry_max <= `RETRY_RESET;
      compare_swap_new_value <= `CSWAP_RESET;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      pready <= 1'b0;
      resource_target <= 4'h0;
    end
    else
    begin
      physical_response_retry_max <= next_phys_max;
      async_response_retry_max <= next_resp_max;
      async_request_retry_max <= next_req_max;
      compare_swap_new_value <= next_compare_swap_new_value;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      pready <= 1'b1;
      resource_target <= next_resource_target;
    end
  end

  // Checks on the sequencer and register file
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence fetch_launch;
    state == eeprom_regs_pkg::ST_IDLE && !eeprom_address_clear && eeprom_read_go && id_eeprom_present;
  endsequence

  sequence fetch_finish;
    state == eeprom_regs_pkg::ST_SW_READ && rd_done && !go_set;
  endsequence

  addr_clear_done_a: assert property ((state == eeprom_regs_pkg::ST_IDLE && eeprom_address_clear && !clear_set)
    |=> !eeprom_address_clear && byte_addr == '0) else $error("address clear not completed");
  no_auto_fill_a: assert property ((state == eeprom_regs_pkg::ST_IDLE && eeprom_address_clear)
    |=> $stable(eeprom_read_byte)) else $error("address clear changed read byte");
  fetch_start_a: assert property (fetch_launch |=> rd_busy && ee_req && ee_addr == $past(byte_addr))
    else $error("read go did not start fetch");
  go_self_clear_a: assert property (fetch_finish |=> !eeprom_read_go && eeprom_read_byte == $past(rd_data))
    else $error("read go not cleared with byte");
  small_rom_set_a: assert property ((state == eeprom_regs_pkg::ST_BOOT_READ && rd_done)
    |=> small_rom_offset == ($past(rd_data[`SMALL_ROM_FLAG_BIT]) ? `SMALL_ROM_VALUE : `SMALL_ROM_RESET))
    else $error("mini ROM pointer wrong");
  access_zero_a: assert property ((setup_phase && paddr == `ADDR_ID_EEPROM)
    |=> prdata[30:26] == 5'h00 && !prdata[24] && prdata[15:8] == 8'h00) else $error("unused bits set");
  retry_zero_a: assert property ((setup_phase && paddr == `ADDR_RETRY) |=> prdata[31:12] == 20'h00000)
    else $error("retry upper bits set");
  retry_write_a: assert property ((wr_access && paddr == `ADDR_RETRY) |=> {physical_response_retry_max,
    async_response_retry_max, async_request_retry_max} == $past(pwdata[11:0]))
    else $error("retry limits not stored");
  cswap_ro_a: assert property ((!cswap_load) |=> $stable(compare_swap_new_value))
    else $error("new value changed without load");
  present_catch_a: assert property ((state == eeprom_regs_pkg::ST_BOOT)
    |=> id_eeprom_present == $past(eeprom_detect) ##1 (state != eeprom_regs_pkg::ST_BOOT))
    else $error("present flag not caught");
  resource_map_a: assert property (1'b1 |=> resource_target == (4'h1 << $past(bus_resource_select)))
    else $error("resource decode wrong");
  zero_write_a: assert property ((!eeprom_address_clear && !clear_set) |=> !eeprom_address_clear)
    else $error("address clear set by zero");

endmodule : eeprom_byte_access_retry_regs

// ---- verilog/eeprom_byte_reader.sv ----
// Single-byte fetch engine toward the serial identifier EEPROM.
// Assumes the EEPROM side answers a held request with a one-cycle ack and valid data.
`timescale 1ns/1ns
module eeprom_byte_reader #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request from the register slice
  input wire logic start,
  input wire logic [ADDR_W-1:0] addr,
  output logic busy,
  output logic done,
  output logic [7:0] data,
  // EEPROM side
  output logic ee_req,
  output logic [ADDR_W-1:0] ee_addr,
  input wire logic ee_ack,
  input wire logic [7:0] ee_data
);

  eeprom_regs_pkg::rd_state_t state, next_state; // Handshake state
  logic next_done; // Completion pulse
  logic [7:0] next_data; // Captured byte
  logic next_ee_req; // Request level
  logic [ADDR_W-1:0] next_ee_addr; // Latched address

  // Next-state logic
  always_comb
  begin
    next_state = state;
    next_done = 1'b0;
    next_data = data;
    next_ee_req = ee_req;
    next_ee_addr = ee_addr;
    case (state)
      eeprom_regs_pkg::RD_IDLE:
      begin
        // Latch address and raise request
        if (start)
        begin
          next_ee_addr = addr;
          next_ee_req = 1'b1;
          next_state = eeprom_regs_pkg::RD_WAIT;
        end
      end
      eeprom_regs_pkg::RD_WAIT:
      begin
        // Capture byte on acknowledge
        if (ee_ack)
        begin
          next_data = ee_data;
          next_done = 1'b1;
          next_ee_req = 1'b0;
          next_state = eeprom_regs_pkg::RD_IDLE;
        end
      end
      default:
      begin
        next_ee_req = 1'b0;
        next_state = eeprom_regs_pkg::RD_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= eeprom_regs_pkg::RD_IDLE;
      done <= 1'b0;
      data <= 8'h00;
      ee_req <= 1'b0;
      ee_addr <= '0;
    end
    else
    begin
      state <= next_state;
      done <= next_done;
      data <= next_data;
      ee_req <= next_ee_req;
      ee_addr <= next_ee_addr;
    end
  end

  // Busy while a request is outstanding
  assign busy = (state != eeprom_regs_pkg::RD_IDLE);

endmodule : eeprom_byte_reader

// ---- verilog/eeprom_regs_consts.svh ----
// Offsets, field positions and reset values of the EEPROM access and retry registers.
// Assumes a 32-bit APB register bus with 8-bit byte addresses.
`ifndef EEPROM_REGS_CONSTS_SVH
`define EEPROM_REGS_CONSTS_SVH

// Register byte offsets
`define ADDR_VERSION 8'h00
`define ADDR_ID_EEPROM 8'h04
`define ADDR_RETRY 8'h08
`define ADDR_CSWAP 8'h0C

// Field positions in the access and version registers
`define EE_CLEAR_BIT 31
`define EE_GO_BIT 25
`define PRESENT_BIT 24

// Field positions in the retry register
`define RETRY_PHYS_LSB 8
`define RETRY_RESP_LSB 4
`define RETRY_REQ_LSB 0

// Fixed values and reset values
`define SMALL_ROM_VALUE 8'h20
`define SMALL_ROM_RESET 8'h00
`define SMALL_ROM_FLAG_ADDR 8'h06
`define SMALL_ROM_FLAG_BIT 5
`define RETRY_RESET 4'h0
`define CSWAP_RESET 32'h00000000
`define VERSION_MAJOR 8'h01
`define VERSION_MINOR 8'h10

`endif

// ---- verilog/eeprom_regs_pkg.sv ----
// Types shared by the register slice and its EEPROM byte reader.
// Assumes the constants header for all numeric values.
package eeprom_regs_pkg;

  // Register slice sequencing, one-hot
  typedef enum logic [3:0] {
    ST_BOOT = 4'b0001,
    ST_BOOT_READ = 4'b0010,
    ST_IDLE = 4'b0100,
    ST_SW_READ = 4'b1000
  } access_state_t;

  // Byte reader handshake, one-hot
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_WAIT = 2'b10
  } rd_state_t;

  // Compare-swap bus resource selector
  typedef enum logic [1:0] {
    RES_BUS_MANAGER_ID = 2'b00,
    RES_BANDWIDTH_AVAILABLE = 2'b01,
    RES_CHANNELS_AVAILABLE_HI = 2'b10,
    RES_CHANNELS_AVAILABLE_LO = 2'b11
  } bus_resource_t;

endpackage : eeprom_regs_pkg
